// [hdl/channel_fir.sv]
// 16-tap symmetric lowpass on both i and q, with a dc canceller ahead of it
// assumes one sample per in_valid on the same clock
`timescale 1ns/10ps
`include "rx_chain_defs.svh"
module channel_fir (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire rx_chain_pkg::sample_t i_i,
   input wire rx_chain_pkg::sample_t q_i,
   input wire logic [2:0] dcc_shift_i,
   input wire logic [2:0] bw_shift_i,
   vector_if.filt out
);
   rx_chain_pkg::sample_t di [`TAPS];
   rx_chain_pkg::sample_t dq [`TAPS];
   logic signed [23:0] dc_i;
   logic signed [23:0] dc_q;
   logic signed [17:0] acc_i;
   logic signed [17:0] acc_q;

   // triangular coefficients; the exponent's low two bits only lower the gain by extra right shift of the output
   function automatic logic signed [5:0] coef(input int k);
      logic [3:0] m;
      m = (k < 8) ? 4'(k) : 4'(15 - k);
      return 6'(2 + 3 * int'(m));
   endfunction

   // dc estimate leaks by 2^-(dcc+4): cutoff halves with each code step
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dc_i <= '0;
         dc_q <= '0;
      end else if (in_valid_i) begin
         dc_i <= dc_i + (((24'(i_i) <<< 8) - dc_i) >>> (4'(dcc_shift_i) + 4'h4));
         dc_q <= dc_q + (((24'(q_i) <<< 8) - dc_q) >>> (4'(dcc_shift_i) + 4'h4));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < `TAPS; k++) begin
            di[k] <= '0;
            dq[k] <= '0;
         end
      end else if (in_valid_i) begin
         di[0] <= 12'(i_i - 12'(dc_i >>> 8));
         dq[0] <= 12'(q_i - 12'(dc_q >>> 8));
         for (int k = 1; k < `TAPS; k++) begin
            di[k] <= di[k-1];
            dq[k] <= dq[k-1];
         end
      end
   end

   always_comb begin
      acc_i = '0;
      acc_q = '0;
      for (int k = 0; k < `TAPS; k++) begin
         acc_i = acc_i + 18'(di[k] * coef(k));
         acc_q = acc_q + 18'(dq[k] * coef(k));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out.i_s <= '0;
         out.q_s <= '0;
         out.valid <= 1'b0;
      end else begin
         out.i_s <= 12'(acc_i >>> (4'h6 + 4'(bw_shift_i[1:0])));
         out.q_s <= 12'(acc_q >>> (4'h6 + 4'(bw_shift_i[1:0])));
         out.valid <= in_valid_i;
      end
   end
endmodule

// [hdl/rx_baseband_filter_demod.sv]
// receive baseband: channel filter, dc cancel, image filter, vector extraction,
// signal strength, frequency and on-off demodulation, with a wishbone register file
// assumes i/q samples from the decimator at the crystal-derived rate, same clock
// Notes on behaviour
// - sixteen-tap fir filters channel noise
// - fsk bandwidth uses exponent plus two
// - ook bandwidth uses exponent plus three
// - mantissa codes mean 16, 20, 24
// - 32 MHz reference, 500/250 kHz at 16,0
// - dcc cutoff halves per code step
// - dcc cutoff resets to code 010
// - ook uses low if, half bandwidth
// - image filter only in ook mode
// - half-dB strength steps, two-bit acquisition
// - strength readable only above limit
// - gain calibration runs automatically at startup
// - cordic feeds phase and magnitude users
// - frequency demod handles fsk family signals
// - frequency demod feeds bit synchronizer
// - ook compares strength against selected threshold
// - peak threshold is peak minus six dB
// - peak decays by step plus one each period
// - decay stops at floor threshold
// - fixed uses floor, average uses mean
`timescale 1ns/10ps
`include "rx_chain_defs.svh"
module rx_baseband_filter_demod (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic sample_valid_i,
   input wire rx_chain_pkg::sample_t i_sample_i,
   input wire rx_chain_pkg::sample_t q_sample_i,
   input wire logic synth_startup_i,
   output logic cal_inject_o,
   output logic [23:0] lo_offset_hz_o,
   output logic [19:0] channel_bandwidth_hz_o,
   output logic data_o,
   output logic data_valid_o,
   output logic bitsync_data_o
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   rx_chain_pkg::modulation_t modulation_select;
   logic [1:0] bandwidth_mantissa;
   logic [2:0] bandwidth_exponent;
   logic [2:0] offset_cancel_cutoff;
   logic [7:0] signal_strength_limit;
   logic [2:0] peak_decay_step;
   logic [2:0] peak_decay_period;
   rx_chain_pkg::onoff_threshold_kind_t onoff_threshold_kind;
   logic [7:0] floor_threshold_level;
   logic [15:0] bit_period;
   logic continuous_route;
   logic [7:0] signal_strength_value;
   logic strength_above;
   logic cal_done;
   logic [7:0] gain_trim;

   logic wb_req;
   logic synth_q1;
   logic synth_q2;
   logic synth_prev;

   assign wb_req = cyc_i && stb_i && !ack_o;

   function automatic logic [7:0] lane_byte(input logic [31:0] d, input logic [7:0] old,
         input logic s);
      return s ? d[7:0] : old;
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         modulation_select <= rx_chain_pkg::modulation_t'(`RST_MODULATION);
         bandwidth_mantissa <= `RST_MANT;
         bandwidth_exponent <= `RST_EXP;
         offset_cancel_cutoff <= `RST_DCC;
         signal_strength_limit <= `RST_LIMIT;
         peak_decay_step <= `RST_STEP;
         peak_decay_period <= `RST_PERIOD;
         onoff_threshold_kind <= rx_chain_pkg::onoff_threshold_kind_t'(`RST_KIND);
         floor_threshold_level <= `RST_FLOOR;
         bit_period <= `RST_BIT_PERIOD;
         continuous_route <= 1'b1;
      end else if (cyc_i && stb_i && ack_o && we_i && sel_i[0]) begin
         unique case (adr_i)
            `ADDR_MODULATION_CONFIG: begin
               modulation_select <= (dat_i[1:0] == 2'h1) ? rx_chain_pkg::mod_ook
                  : rx_chain_pkg::mod_fsk;
               continuous_route <= dat_i[2];
            end
            `ADDR_CHANNEL_FILTER_CONFIG: begin
               // code 11 is not a mantissa; keep the previous one
               if (dat_i[`FLD_MANT_LO+:2] != 2'h3) begin
                  bandwidth_mantissa <= dat_i[`FLD_MANT_LO+:2];
               end
               bandwidth_exponent <= dat_i[`FLD_EXP_LO+:3];
               offset_cancel_cutoff <= dat_i[`FLD_DCC_LO+:3];
            end
            `ADDR_SIGNAL_STRENGTH_LIMIT: begin
               signal_strength_limit <= lane_byte(dat_i, signal_strength_limit, 1'b1);
            end
            `ADDR_ONOFF_PEAK_CONFIG: begin
               peak_decay_step <= dat_i[`FLD_STEP_LO+:3];
               peak_decay_period <= dat_i[`FLD_PERIOD_LO+:3];
               if (dat_i[`FLD_KIND_LO+:2] != 2'h3) begin
                  onoff_threshold_kind <=
                     rx_chain_pkg::onoff_threshold_kind_t'(dat_i[`FLD_KIND_LO+:2]);
               end
            end
            `ADDR_FLOOR_THRESHOLD: begin
               floor_threshold_level <= dat_i[7:0];
            end
            `ADDR_BIT_PERIOD: begin
               if (sel_i[1]) begin
                  bit_period <= dat_i[15:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // single-wait-state slave: ack one cycle after the request, then low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end else begin
         ack_o <= wb_req;
         if (wb_req && !we_i) begin
            unique case (adr_i)
               `ADDR_MODULATION_CONFIG:
                  dat_o <= {29'h0, continuous_route, modulation_select};
               `ADDR_CHANNEL_FILTER_CONFIG:
                  dat_o <= {24'h0, offset_cancel_cutoff, bandwidth_exponent,
                     bandwidth_mantissa};
               `ADDR_SIGNAL_STRENGTH_LIMIT: dat_o <= {24'h0, signal_strength_limit};
               `ADDR_ONOFF_PEAK_CONFIG:
                  dat_o <= {24'h0, onoff_threshold_kind, peak_decay_period, peak_decay_step};
               `ADDR_FLOOR_THRESHOLD: dat_o <= {24'h0, floor_threshold_level};
               // strength is hidden until it passes the limit
               `ADDR_SIGNAL_STRENGTH:
                  dat_o <= {24'h0, strength_above ? signal_strength_value : 8'h00};
               `ADDR_STATUS: dat_o <= {30'h0, cal_done, strength_above};
               `ADDR_BIT_PERIOD: dat_o <= {16'h0, bit_period};
               default: dat_o <= '0;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // bandwidth and low-if
   // ------------------------------------------------------------
   logic [4:0] mant_value;
   logic [3:0] bw_shift;
   logic [31:0] next_bw;

   always_comb begin
      unique case (bandwidth_mantissa)
         2'h0: mant_value = 5'd16;
         2'h1: mant_value = 5'd20;
         default: mant_value = 5'd24;
      endcase
      // ook divides by one more power of two
      bw_shift = {1'b0, bandwidth_exponent} + ((modulation_select == rx_chain_pkg::mod_ook)
         ? 4'h3 : 4'h2);
      next_bw = 32'(`CRYSTAL_FREQUENCY_HZ) / (32'(mant_value) << bw_shift);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_bandwidth_hz_o <= '0;
         lo_offset_hz_o <= '0;
      end else begin
         channel_bandwidth_hz_o <= next_bw[19:0];
         lo_offset_hz_o <= (modulation_select == rx_chain_pkg::mod_ook)
            ? 24'(next_bw >> 1) : 24'h0;
      end
   end

   // ------------------------------------------------------------
   // gain calibration at synthesizer start
   // ------------------------------------------------------------
   logic [7:0] cal_count;
   logic [11:0] cal_mag;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         synth_q1 <= 1'b0;
         synth_q2 <= 1'b0;
         synth_prev <= 1'b0;
      end else begin
         synth_q1 <= synth_startup_i;
         synth_q2 <= synth_q1;
         synth_prev <= synth_q2;
      end
   end

   vector_if vif ();

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_inject_o <= 1'b0;
         cal_count <= '0;
         cal_done <= 1'b0;
         gain_trim <= '0;
         cal_mag <= '0;
      end else if (synth_q2 && !synth_prev) begin
         cal_inject_o <= 1'b1;
         cal_count <= `CAL_CYCLES;
         cal_done <= 1'b0;
      end else if (cal_inject_o) begin
         if (vif.mag_valid) begin
            cal_mag <= vif.magnitude;
         end
         cal_count <= cal_count - 8'h1;
         if (cal_count == 8'h1) begin
            cal_inject_o <= 1'b0;
            cal_done <= 1'b1;
            // trim so the known reference lands at mid-scale
            gain_trim <= 8'(8'h80 - cal_mag[11:4]);
         end
      end
   end

   // ------------------------------------------------------------
   // filtering, image rejection, vector extraction
   // ------------------------------------------------------------
   rx_chain_pkg::sample_t img_i;
   rx_chain_pkg::sample_t img_q;
   rx_chain_pkg::sample_t prev_i;
   rx_chain_pkg::sample_t prev_q;

   // image filter: a two-tap complex section on the current and previous sample, tuned to +if; fsk bypasses it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_i <= '0;
         prev_q <= '0;
      end else if (sample_valid_i) begin
         prev_i <= i_sample_i;
         prev_q <= q_sample_i;
      end
   end
   always_comb begin
      if (modulation_select == rx_chain_pkg::mod_ook) begin
         img_i = 12'((13'(i_sample_i) + 13'(prev_q)) >>> 1);
         img_q = 12'((13'(q_sample_i) - 13'(prev_i)) >>> 1);
      end else begin
         img_i = i_sample_i;
         img_q = q_sample_i;
      end
   end

   channel_fir u_fir (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(sample_valid_i),
      .i_i(img_i),
      .q_i(img_q),
      .dcc_shift_i(offset_cancel_cutoff),
      .bw_shift_i(bandwidth_exponent),
      .out(vif.filt)
   );

   vector_extract u_vec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .v(vif.vec)
   );

   // ------------------------------------------------------------
   // signal strength: half-dB steps, window of two bit periods
   // ------------------------------------------------------------
   logic [16:0] acq_count;
   logic [11:0] acq_peak;
   logic [7:0] strength_now;

   // log2 approximation in quarter-octave steps of 3 codes: 6 dB per octave = 12 codes
   function automatic logic [7:0] half_db(input logic [11:0] m, input logic [7:0] trim);
      logic [7:0] r;
      r = 8'h00;
      for (int b = 0; b < 12; b++) begin
         if (m[b]) begin
            r = 8'(12 * b) + 8'(m >> (b > 1 ? b - 2 : 0)) % 8'h4 * 8'h3;
         end
      end
      return 8'(r + trim);
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acq_count <= '0;
         acq_peak <= '0;
         signal_strength_value <= '0;
         strength_above <= 1'b0;
      end else begin
         if (vif.mag_valid && vif.magnitude > acq_peak) begin
            acq_peak <= vif.magnitude;
         end
         if (acq_count >= {bit_period, 1'b0}) begin
            acq_count <= '0;
            acq_peak <= '0;
            signal_strength_value <= half_db(acq_peak, gain_trim);
            strength_above <= half_db(acq_peak, gain_trim) > signal_strength_limit;
         end else begin
            acq_count <= acq_count + 17'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strength_now <= '0;
      end else if (vif.mag_valid) begin
         strength_now <= half_db(vif.magnitude, gain_trim);
      end
   end

   // ------------------------------------------------------------
   // on-off threshold and decision
   // ------------------------------------------------------------
   logic [7:0] held_peak;
   logic [7:0] avg;
   logic [7:0] threshold;
   logic [7:0] peak_minus;
   logic [15:0] decay_count;
   logic decay_tick;

   // decay period in bit fractions: one step every bit_period >> code
   assign decay_tick = decay_count >= (bit_period >> peak_decay_period);
   assign peak_minus = (held_peak > `SIX_DB_STEPS) ? held_peak - `SIX_DB_STEPS : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         decay_count <= '0;
      end else begin
         decay_count <= decay_tick ? 16'h0 : decay_count + 16'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         held_peak <= `RST_FLOOR;
      end else if (strength_now > held_peak) begin
         held_peak <= strength_now;
      end else if (decay_tick && strength_now <= peak_minus) begin
         // only while a zero or nothing is received
         if (held_peak > floor_threshold_level + 8'(peak_decay_step) + 8'h1) begin
            held_peak <= held_peak - 8'(peak_decay_step) - 8'h1;
         end else begin
            held_peak <= floor_threshold_level;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         avg <= '0;
      end else if (vif.mag_valid) begin
         avg <= 8'(avg + 8'($signed(9'(strength_now) - 9'(avg)) >>> 3));
      end
   end

   always_comb begin
      unique case (onoff_threshold_kind)
         rx_chain_pkg::thr_peak: threshold = (peak_minus > floor_threshold_level)
            ? peak_minus : floor_threshold_level;
         rx_chain_pkg::thr_average: threshold = avg;
         default: threshold = floor_threshold_level;
      endcase
   end

   // ------------------------------------------------------------
   // demodulated outputs
   // ------------------------------------------------------------
   logic signed [11:0] last_phase;
   logic signed [11:0] dphase;
   assign dphase = vif.phase - last_phase;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_phase <= '0;
         data_o <= 1'b0;
         data_valid_o <= 1'b0;
         bitsync_data_o <= 1'b0;
      end else begin
         data_valid_o <= vif.mag_valid;
         if (vif.mag_valid) begin
            last_phase <= vif.phase;
            if (modulation_select == rx_chain_pkg::mod_ook) begin
               data_o <= strength_now > threshold;
            end else begin
               data_o <= !dphase[11];
            end
         end
         bitsync_data_o <= continuous_route ? data_o : 1'b0;
      end
   end
endmodule

// [hdl/vector_extract.sv]
// sequential cordic: magnitude and phase of i + jq, 12 iterations per sample
// assumes samples arrive no faster than once per 14 clocks
`timescale 1ns/10ps
module vector_extract (
   input wire logic clk_i,
   input wire logic rst_i,
   vector_if.vec v
);
   logic signed [13:0] x;
   logic signed [13:0] y;
   logic signed [13:0] z;
   logic [3:0] it;
   logic busy;

   function automatic logic signed [13:0] atan_tab(input logic [3:0] n);
      logic signed [13:0] r;
      unique case (n)
         4'h0: r = 14'sh0200;
         4'h1: r = 14'sh012e;
         4'h2: r = 14'sh00a0;
         4'h3: r = 14'sh0051;
         4'h4: r = 14'sh0029;
         4'h5: r = 14'sh0014;
         4'h6: r = 14'sh000a;
         4'h7: r = 14'sh0005;
         default: r = 14'sh0001;
      endcase
      return r;
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         x <= '0;
         y <= '0;
         z <= '0;
         it <= '0;
         busy <= 1'b0;
         v.magnitude <= '0;
         v.phase <= '0;
         v.mag_valid <= 1'b0;
      end else begin
         v.mag_valid <= 1'b0;
         if (!busy && v.valid) begin
            // fold into right half-plane, phase offset by half turn
            x <= (v.i_s < 0) ? -14'(v.i_s) : 14'(v.i_s);
            y <= (v.i_s < 0) ? -14'(v.q_s) : 14'(v.q_s);
            z <= (v.i_s < 0) ? 14'sh0800 : 14'sh0000;
            it <= '0;
            busy <= 1'b1;
         end else if (busy) begin
            if (y >= 0) begin
               x <= x + (y >>> it);
               y <= y - (x >>> it);
               z <= z + atan_tab(it);
            end else begin
               x <= x - (y >>> it);
               y <= y + (x >>> it);
               z <= z - atan_tab(it);
            end
            it <= it + 4'h1;
            if (it == 4'hb) begin
               busy <= 1'b0;
               v.magnitude <= 12'(x >>> 1);
               v.phase <= 12'(z >>> 1);
               v.mag_valid <= 1'b1;
            end
         end
      end
   end
endmodule

// [pkg/rx_chain_defs.svh]
// offsets, field positions, reset values and timing counts of the receive chain
// assumes inclusion by bare name from package and design files
`ifndef RX_CHAIN_DEFS_SVH
`define RX_CHAIN_DEFS_SVH

// ------------------------------------------------------------
// register byte addresses (32-bit words)
// ------------------------------------------------------------
`define ADDR_MODULATION_CONFIG 6'h00
`define ADDR_CHANNEL_FILTER_CONFIG 6'h04
`define ADDR_SIGNAL_STRENGTH_LIMIT 6'h08
`define ADDR_ONOFF_PEAK_CONFIG 6'h0c
`define ADDR_FLOOR_THRESHOLD 6'h10
`define ADDR_SIGNAL_STRENGTH 6'h14
`define ADDR_STATUS 6'h18
`define ADDR_BIT_PERIOD 6'h1c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FLD_MANT_LO 0
`define FLD_EXP_LO 2
`define FLD_DCC_LO 5
`define FLD_STEP_LO 0
`define FLD_PERIOD_LO 3
`define FLD_KIND_LO 6

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_MODULATION 2'h0
`define RST_MANT 2'h2
`define RST_EXP 3'h5
`define RST_DCC 3'h2
`define RST_LIMIT 8'he4
`define RST_STEP 3'h0
`define RST_PERIOD 3'h0
`define RST_KIND 2'h1
`define RST_FLOOR 8'h06
`define RST_BIT_PERIOD 16'h0064

// ------------------------------------------------------------
// timing and scaling
// ------------------------------------------------------------
`define CRYSTAL_FREQUENCY_HZ 32000000
`define CLK_HZ 125000000
`define CYC_PER_SAMPLE ((`CLK_HZ + `CRYSTAL_FREQUENCY_HZ - 1) / `CRYSTAL_FREQUENCY_HZ)
`define SIX_DB_STEPS 8'h0c
`define CAL_CYCLES 8'h40
`define TAPS 16

`endif

// [pkg/rx_chain_pkg.sv]
// types shared by the receive chain modules
package rx_chain_pkg;
   typedef enum logic [1:0] {
      mod_fsk = 2'h0,
      mod_ook = 2'h1
   } modulation_t;

   typedef enum logic [1:0] {
      thr_fixed = 2'h0,
      thr_peak = 2'h1,
      thr_average = 2'h2
   } onoff_threshold_kind_t;

   typedef logic signed [11:0] sample_t;
endpackage

// [pkg/vector_if.sv]
// carries filtered i/q samples and the extracted magnitude/phase between modules
`timescale 1ns/10ps
interface vector_if;
   rx_chain_pkg::sample_t i_s;
   rx_chain_pkg::sample_t q_s;
   logic valid;
   logic [11:0] magnitude;
   logic signed [11:0] phase;
   logic mag_valid;
   modport filt (output i_s, output q_s, output valid);
   modport vec (input i_s, input q_s, input valid, output magnitude, output phase,
      output mag_valid);
   modport sink (input magnitude, input phase, input mag_valid);
endinterface

// [testbench/iq_source_model.sv]
// far transmitter: keyed constant carrier at the centre of the channel
// assumes one sample every 16 clocks, above the 14-clock minimum
`timescale 1ns/10ps
module iq_source_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic key_i,
   output logic valid_o,
   output rx_chain_pkg::sample_t i_o,
   output rx_chain_pkg::sample_t q_o
);
   logic [3:0] cnt;
   rx_chain_pkg::sample_t amp;
   assign amp = key_i ? 12'sh3e8 : 12'sh000;
   always_ff @(posedge clk_i) begin
      cnt <= rst_i ? 4'h0 : cnt + 4'h1;
      valid_o <= !rst_i && cnt == 4'hf;
      // in-band tone; a quarter-rate one sits in a filter null
      i_o <= amp;
      q_o <= 12'sh000;
   end
endmodule

// [testbench/rx_baseband_filter_demod_asserts.sv]
// checker on the top ports of the receive chain
// assumes it is bound onto every instance of the top module
`timescale 1ns/10ps
module rx_baseband_filter_demod_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic cal_inject_o,
   input wire logic [23:0] lo_offset_hz_o,
   input wire logic [19:0] channel_bandwidth_hz_o,
   input wire logic data_o,
   input wire logic data_valid_o,
   input wire logic bitsync_data_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_cal_len; $rose(cal_inject_o) |=> cal_inject_o [*8]; endproperty
   a_cal_len: assert property (p_cal_len) else $error("inject pulse too short");
   property p_bw_max; channel_bandwidth_hz_o <= 20'h7a120; endproperty
   a_bw_max: assert property (p_bw_max) else $error("bandwidth above maximum");
   // the offset is registered on the same edge as the bandwidth, from the same quotient
   property p_lo_half; lo_offset_hz_o != 24'h0 && $stable(channel_bandwidth_hz_o)
      |-> lo_offset_hz_o == {5'h0, channel_bandwidth_hz_o[19:1]}; endproperty
   a_lo_half: assert property (p_lo_half) else $error("offset not half bandwidth");
   property p_bitsync; bitsync_data_o |-> $past(data_o); endproperty
   a_bitsync: assert property (p_bitsync) else $error("bitsync not delayed data");
   property p_valid; data_valid_o |=> !data_valid_o; endproperty
   a_valid: assert property (p_valid) else $error("valid longer than a pulse");
endmodule
bind rx_baseband_filter_demod rx_baseband_filter_demod_asserts u_chk (.clk_i(clk_i),
   .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .cal_inject_o(cal_inject_o),
   .lo_offset_hz_o(lo_offset_hz_o), .channel_bandwidth_hz_o(channel_bandwidth_hz_o),
   .data_o(data_o), .data_valid_o(data_valid_o), .bitsync_data_o(bitsync_data_o));

// [testbench/tb_rx_baseband_filter_demod.sv]
// bench for the receive chain: wishbone access, keyed iq source, demod checks
// assumes the checker is bound and the iq model stands for the transmitter
`timescale 1ns/10ps
module tb_rx_baseband_filter_demod;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [5:0] adr_i = 6'h00;
   logic [31:0] dat_i = 32'h0;
   logic synth_startup_i = 1'b0;
   logic key = 1'b0;
   logic sample_valid_i, ack_o, cal_inject_o, data_o, data_valid_o, bs;
   rx_chain_pkg::sample_t i_s, q_s;
   logic [31:0] dat_o, q;
   logic [23:0] lo_offset_hz_o;
   logic [19:0] channel_bandwidth_hz_o;
   logic [5:0] ra [7] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h1c, 6'h20};
   logic [31:0] rv [7] = '{32'h4, 32'h56, 32'he4, 32'h40, 32'h6, 32'h64, 32'h0};
   int n_mismatch = 0;
   int num_checks = 0;
   int bw;
   int cnt;
   always #4 clk_i = ~clk_i;
   iq_source_model u_iq_source_model (.clk_i(clk_i), .rst_i(rst_i), .key_i(key),
      .valid_o(sample_valid_i), .i_o(i_s), .q_o(q_s));
   rx_baseband_filter_demod u_rx_baseband_filter_demod (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .sample_valid_i(sample_valid_i), .i_sample_i(i_s),
      .q_sample_i(q_s), .synth_startup_i(synth_startup_i), .cal_inject_o(cal_inject_o),
      .lo_offset_hz_o(lo_offset_hz_o), .channel_bandwidth_hz_o(channel_bandwidth_hz_o),
      .data_o(data_o), .data_valid_o(data_valid_o), .bitsync_data_o(bs));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // holds the request until ack is sampled high, then releases for one cycle
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      int t = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         t++;
      end while (ack_o !== 1'b1 && t < 40);
      q = dat_o;
      if (ack_o !== 1'b1) n_mismatch++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic demod(input logic k, input logic e);
      key <= k;
      repeat (1200) @(posedge clk_i);
      for (int t = 0; t < 40 && data_valid_o !== 1'b1; t++) @(posedge clk_i);
      chk({31'h0, data_o}, {31'h0, e});
      @(posedge clk_i);
      chk({31'h0, bs}, {31'h0, e});
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ra[n]) begin
         wb(1'b0, ra[n], 32'h0);
         chk(q, rv[n]);
      end
      wb(1'b1, 6'h04, 32'hff);
      wb(1'b0, 6'h04, 32'h0);
      chk(q, 32'hfe);
      for (int o = 0; o < 2; o++) begin
         wb(1'b1, 6'h00, 32'(4 + o));
         for (int m = 0; m < 3; m++) begin
            for (int e = 0; e < 8; e++) begin
               wb(1'b1, 6'h04, 32'(64 + e * 4 + m));
               repeat (3) @(posedge clk_i);
               bw = 32000000 / ((16 + 4 * m) << (e + 2 + o));
               chk({12'h0, channel_bandwidth_hz_o}, 32'(bw));
               chk({8'h0, lo_offset_hz_o}, 32'(o * bw / 2));
            end
         end
      end
      wb(1'b1, 6'h04, 32'he0);
      wb(1'b1, 6'h10, 32'h64);
      wb(1'b1, 6'h1c, 32'h14);
      for (int k = 0; k < 3; k++) begin
         wb(1'b1, 6'h0c, 32'(k * 64));
         demod(1'b1, 1'b1);
         demod(1'b0, 1'b0);
      end
      wb(1'b0, 6'h14, 32'h0);
      chk(q, 32'h0);
      synth_startup_i <= 1'b1;
      cnt = 0;
      repeat (200) begin
         @(posedge clk_i);
         cnt += int'(cal_inject_o === 1'b1);
      end
      chk(32'(cnt), 32'h40);
      wb(1'b0, 6'h18, 32'h0);
      chk(q & 32'h2, 32'h2);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      finish_test();
   end
endmodule
